// File: src/hbi_pkg.sv
// Constants, coefficient tables and helpers for the half-band interpolation chain
package hbi_pkg;
   // Sample and accumulator widths, tap and stage counts, phase counter width
   localparam int DW = 16;
   localparam int AW = 40;
   localparam int NSMAX = 11;
   localparam int NSTAGE = 3;
   localparam int HALF_W = 4;

   // Interpolation rate setting
   typedef enum logic [1:0] {HBI_X1, HBI_X2, HBI_X4, HBI_X8} hbi_rate_t;

   // Nonzero side taps only (odd tap numbers 1,3,5..), zero taps are implied
   localparam logic signed [DW-1:0] HB_COEF [0:NSTAGE-1][0:NSMAX-1] = '{
      '{16'sh0008, -16'sh001d, 16'sh0043, -16'sh0086, 16'sh00f4, -16'sh019e,
        16'sh02a1, -16'sh0437, 16'sh06ec, -16'sh0cd0, 16'sh287c},
      '{16'sh0013, -16'sh0078, 16'sh01b6, -16'sh0508, 16'sh13b7, 16'sh0000,
        16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000},
      '{16'sh0007, -16'sh0035, 16'sh012e, 16'sh0000, 16'sh0000, 16'sh0000,
        16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000}};

   // Count of nonzero side taps per stage (43, 19 and 11 tap filters)
   localparam int HB_NS [0:NSTAGE-1] = '{11, 5, 3};
   // Centre taps are powers of two: 16384, 8192, 512
   localparam int HB_CSH [0:NSTAGE-1] = '{14, 13, 9};

   // Cycles between a stage's two output phases, indexed by stage then rate
   localparam logic [HALF_W-1:0] HB_HALF [0:NSTAGE-1][0:3] = '{
      '{4'h0, 4'h1, 4'h2, 4'h4},
      '{4'h0, 4'h0, 4'h1, 4'h2},
      '{4'h0, 4'h0, 4'h0, 4'h1}};

   // Clamp a wide result into the sample range
   function automatic logic signed [DW-1:0] sat(input logic signed [AW-1:0] v);
      logic signed [AW-1:0] hi;
      logic signed [AW-1:0] lo;
      hi = AW'(16'sh7fff);
      lo = AW'(16'sh8000); // Sign extends to the most negative sample
      if (v > hi) begin
         return 16'sh7fff;
      end else if (v < lo) begin
         return 16'sh8000;
      end
      return v[DW-1:0];
   endfunction
endpackage

// File: src/hbi_hb_stage.sv
// One symmetric half-band 2x interpolator stage, I and Q together
`timescale 1ns/100ps
`default_nettype none
module hbi_hb_stage #(
   parameter int SEL = 0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Input samples
   input wire logic in_vld,
   input wire logic signed [hbi_pkg::DW-1:0] in_i,
   input wire logic signed [hbi_pkg::DW-1:0] in_q,
   // Setup
   input wire logic [hbi_pkg::HALF_W-1:0] half_per,
   input wire logic stuff,
   // Output samples at twice the input rate
   output logic out_vld,
   output logic signed [hbi_pkg::DW-1:0] out_i,
   output logic signed [hbi_pkg::DW-1:0] out_q
);
   localparam int NS = hbi_pkg::HB_NS[SEL];
   localparam int HL = 2 * NS;
   localparam int CSH = hbi_pkg::HB_CSH[SEL];

   logic signed [hbi_pkg::DW-1:0] hist_i_reg [0:HL-1];
   logic signed [hbi_pkg::DW-1:0] hist_q_reg [0:HL-1];
   logic ev_pend_reg;
   logic [hbi_pkg::HALF_W-1:0] cnt_reg;
   logic odd_now;

   // Even phase: paired symmetric taps, one multiply per pair
   function automatic logic signed [hbi_pkg::AW-1:0] even_sum(
      input logic signed [hbi_pkg::DW-1:0] h [0:HL-1]);
      logic signed [hbi_pkg::AW-1:0] acc;
      acc = '0;
      for (int k = 0; k < NS; k++) begin
         acc = acc + hbi_pkg::AW'(hbi_pkg::HB_COEF[SEL][k]) *
               (hbi_pkg::AW'(h[k]) + hbi_pkg::AW'(h[HL-1-k]));
      end
      return acc;
   endfunction

   // Normalise by the centre tap; zero stuffing halves the gain
   function automatic logic signed [hbi_pkg::DW-1:0] scale(
      input logic signed [hbi_pkg::AW-1:0] a, input logic st);
      return hbi_pkg::sat(st ? (a >>> (CSH + 1)) : (a >>> CSH));
   endfunction

   // Odd phase is the centre tap alone, so it is a delayed copy, halved when stuffing
   function automatic logic signed [hbi_pkg::DW-1:0] centre(
      input logic signed [hbi_pkg::DW-1:0] x, input logic st);
      return scale(hbi_pkg::AW'(x) <<< CSH, st);
   endfunction

   // History line, shifted once per input sample
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int k = 0; k < HL; k++) begin
            hist_i_reg[k] <= '0;
            hist_q_reg[k] <= '0;
         end
      end else if (in_vld) begin
         hist_i_reg[0] <= in_i;
         hist_q_reg[0] <= in_q;
         for (int k = 1; k < HL; k++) begin
            hist_i_reg[k] <= hist_i_reg[k-1];
            hist_q_reg[k] <= hist_q_reg[k-1];
         end
      end
   end

   // Phase sequencing: even one cycle after the input, odd half a period later
   assign odd_now = (cnt_reg == 4'h1);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ev_pend_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         ev_pend_reg <= in_vld;
         if (ev_pend_reg) begin
            cnt_reg <= half_per;
         end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 4'h1;
         end
      end
   end

   // Output register, fixed latency independent of the signal
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         out_vld <= 1'b0;
         out_i <= '0;
         out_q <= '0;
      end else begin
         out_vld <= ev_pend_reg | (odd_now & ~ev_pend_reg);
         if (ev_pend_reg) begin
            out_i <= scale(even_sum(hist_i_reg), stuff);
            out_q <= scale(even_sum(hist_q_reg), stuff);
         end else if (odd_now) begin
            out_i <= centre(hist_i_reg[NS-1], stuff);
            out_q <= centre(hist_q_reg[NS-1], stuff);
         end
      end
   end

   even_lat_a: assert property (@(posedge clk_sys) disable iff (rst)
      in_vld |-> ##2 out_vld) else $error("even phase late");
   centre_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
      odd_now && !ev_pend_reg && !stuff && !in_vld |=> out_i == $past(hist_i_reg[NS-1]))
      else $error("odd phase is not the centre sample");
   stuff_gain_a: assert property (@(posedge clk_sys) disable iff (rst)
      odd_now && !ev_pend_reg && stuff |=> out_q == ($past(hist_q_reg[NS-1]) >>> 1))
      else $error("zero stuffed gain wrong");
   odd_spacing_a: assert property (@(posedge clk_sys) disable iff (rst)
      in_vld && half_per == 4'h1 |-> ##2 out_vld ##1 out_vld) else $error("odd phase spacing");
endmodule
`default_nettype wire

// File: src/hbi_chain.sv
// Interpolating half-band filter chain for the I and Q transmit streams
// Operation
// - The first stage is a symmetric 43-tap half-band filter with the listed taps and a centre of 16384.
// - The second stage is a symmetric 19-tap half-band filter with the listed taps and a centre of 8192.
// - The third stage is a symmetric 11-tap half-band filter with the listed taps and a centre of 512.
// - Every stage has a fixed delay from input sample to output, whatever the signal.
// - Processing runs at a multiple of the input rate so images near the output rate are suppressed.
// - A two-bit setting picks 1x, 2x, 4x or 8x interpolation.
// - A control bit halves the gain of every stage when set, as zero stuffing would, and leaves the gain unhalved when clear.
`timescale 1ns/100ps
`default_nettype none
module hbi_chain (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Setup, held steady while streaming
   input wire logic [1:0] rate_sel,
   input wire logic zero_stuff,
   // Source samples, one strobe per input sample period
   input wire logic in_vld,
   input wire logic signed [hbi_pkg::DW-1:0] i_in,
   input wire logic signed [hbi_pkg::DW-1:0] q_in,
   // Samples toward the DAC core
   output logic out_vld,
   output logic signed [hbi_pkg::DW-1:0] i_out,
   output logic signed [hbi_pkg::DW-1:0] q_out
);
   hbi_pkg::hbi_rate_t rate;
   logic s1_vld;
   logic s2_vld;
   logic s3_vld;
   logic signed [hbi_pkg::DW-1:0] s1_i;
   logic signed [hbi_pkg::DW-1:0] s1_q;
   logic signed [hbi_pkg::DW-1:0] s2_i;
   logic signed [hbi_pkg::DW-1:0] s2_q;
   logic signed [hbi_pkg::DW-1:0] s3_i;
   logic signed [hbi_pkg::DW-1:0] s3_q;
   logic [hbi_pkg::HALF_W-1:0] half1;
   logic [hbi_pkg::HALF_W-1:0] half2;
   logic [hbi_pkg::HALF_W-1:0] half3;

   // Rate decode; the source must pace its strobe at one per 2^rate cycles
   assign rate = hbi_pkg::hbi_rate_t'(rate_sel);
   assign half1 = hbi_pkg::HB_HALF[0][rate_sel];
   assign half2 = hbi_pkg::HB_HALF[1][rate_sel];
   assign half3 = hbi_pkg::HB_HALF[2][rate_sel];

   // Stage one, fed from the source
   hbi_hb_stage #(.SEL(0)) u_hb1 (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_vld(in_vld),
      .in_i(i_in),
      .in_q(q_in),
      .half_per(half1),
      .stuff(zero_stuff),
      .out_vld(s1_vld),
      .out_i(s1_i),
      .out_q(s1_q)
   );

   // Stage two, fed from stage one
   hbi_hb_stage #(.SEL(1)) u_hb2 (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_vld(s1_vld),
      .in_i(s1_i),
      .in_q(s1_q),
      .half_per(half2),
      .stuff(zero_stuff),
      .out_vld(s2_vld),
      .out_i(s2_i),
      .out_q(s2_q)
   );

   // Stage three, fed from stage two
   hbi_hb_stage #(.SEL(2)) u_hb3 (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_vld(s2_vld),
      .in_i(s2_i),
      .in_q(s2_q),
      .half_per(half3),
      .stuff(zero_stuff),
      .out_vld(s3_vld),
      .out_i(s3_i),
      .out_q(s3_q)
   );

   // Output select by cascade depth; unused stages keep running, which
   // costs a little power but avoids a restart transient on a rate change
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         out_vld <= 1'b0;
         i_out <= '0;
         q_out <= '0;
      end else begin
         case (rate)
            hbi_pkg::HBI_X1: begin
               out_vld <= in_vld;
               i_out <= i_in;
               q_out <= q_in;
            end
            hbi_pkg::HBI_X2: begin
               out_vld <= s1_vld;
               i_out <= s1_i;
               q_out <= s1_q;
            end
            hbi_pkg::HBI_X4: begin
               out_vld <= s2_vld;
               i_out <= s2_i;
               q_out <= s2_q;
            end
            hbi_pkg::HBI_X8: begin
               out_vld <= s3_vld;
               i_out <= s3_i;
               q_out <= s3_q;
            end
            default: begin
               out_vld <= 1'b0;
               i_out <= '0;
               q_out <= '0;
            end
         endcase
      end
   end

   // Output bursts per input sample at each rate
   sequence burst2_s;
      out_vld ##1 out_vld;
   endsequence

   sequence burst4_s;
      out_vld [*4];
   endsequence

   sequence burst8_s;
      out_vld [*8];
   endsequence

   bypass_path_a: assert property (@(posedge clk_sys) disable iff (rst)
      rate_sel == 2'h0 && in_vld |=> out_vld && i_out == $past(i_in) && q_out == $past(q_in))
      else $error("bypass path altered the sample");

   bypass_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
      rate_sel == 2'h0 && !in_vld |=> !out_vld) else $error("bypass output without input");

   rate2_pace_a: assert property (@(posedge clk_sys) disable iff (rst)
      rate_sel == 2'h1 && $stable(rate_sel) && in_vld |-> ##3 burst2_s)
      else $error("2x does not give two samples");

   rate4_pace_a: assert property (@(posedge clk_sys) disable iff (rst)
      rate_sel == 2'h2 && in_vld ##1 rate_sel == 2'h2 |-> ##4 burst4_s)
      else $error("4x does not give four samples");

   rate8_pace_a: assert property (@(posedge clk_sys) disable iff (rst)
      rate_sel == 2'h3 && in_vld ##1 rate_sel == 2'h3 |-> ##6 burst8_s)
      else $error("8x does not give eight samples");

   // First sample after idle: two quiet cycles, then the even phase, every time
   fixed_delay_a: assert property (@(posedge clk_sys) disable iff (rst)
      rate_sel == 2'h1 && in_vld && !s1_vld ##1 rate_sel == 2'h1 |-> !out_vld [*2] ##1 out_vld)
      else $error("stage delay not fixed");
endmodule
`default_nettype wire

// File: verification/hbi_src.sv
// Sample source model that feeds impulse bursts into the interpolation chain
`timescale 1ns/100ps
`default_nettype none
module hbi_src (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Run control
   input wire logic go,
   input wire logic [1:0] rate,
   input wire logic signed [hbi_pkg::DW-1:0] amp,
   output logic busy,
   // Sample port
   output logic in_vld,
   output logic signed [hbi_pkg::DW-1:0] i_in,
   output logic signed [hbi_pkg::DW-1:0] q_in
);
   int n;
   // Idle lines start with a pattern, not zero; one process owns every output
   initial begin
      busy = 1'b0;
      in_vld = 1'b0;
      i_in = 16'h5a5a;
      q_in = 16'ha5a5;
      // Impulse on I, its negative on Q, then zeros, one strobe per 2^rate cycles
      forever begin
         @(negedge clk_sys iff (go === 1'b1));
         busy = 1'b1;
         for (n = 0; n < 40 && rst !== 1'b1; n++) begin
            in_vld = 1'b1;
            i_in = (n == 0) ? amp : 16'sh0000;
            q_in = (n == 0) ? -amp : 16'sh0000;
            @(negedge clk_sys);
            // Released lines flip so stale data cannot pass for a sample
            if (rate != 2'h0 || n == 39) begin
               in_vld = 1'b0;
               i_in = ~i_in;
               q_in = ~q_in;
            end
            repeat ((1 << rate) - 1) @(negedge clk_sys);
         end
         busy = 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: verification/hbi_chain_tb.sv
// Self-checking bench for the half-band interpolation chain
`timescale 1ns/100ps
`default_nettype none
module hbi_chain_tb;
   typedef struct {logic [1:0] r; logic z; logic signed [15:0] a; int lat; int nout;} hbi_row_t;
   // Rate, stuffing, amplitude, then latency and output count they should give
   // Latency is launch edge minus taking edge: bypass shares the edge, each stage adds two
   hbi_row_t rows [0:6] = '{'{2'h0, 1'b0, 16'sh1234, 0, 40}, '{2'h1, 1'b0, 16'sh4000, 2, 80},
      '{2'h2, 1'b0, 16'sh4000, 4, 160}, '{2'h3, 1'b0, 16'sh4000, 6, 320},
      '{2'h1, 1'b1, 16'sh4000, 2, 80}, '{2'h3, 1'b1, 16'sh2001, 6, 320},
      '{2'h1, 1'b0, 16'sh7fff, 2, 80}};
   int side [0:2][0:10] = '{'{8, -29, 67, -134, 244, -414, 673, -1079, 1772, -3280, 10364},
      '{19, -120, 438, -1288, 5047, 0, 0, 0, 0, 0, 0}, '{7, -53, 302, 0, 0, 0, 0, 0, 0, 0, 0}};
   int ntap [0:2] = '{43, 19, 11};
   int csh [0:2] = '{14, 13, 9};
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [1:0] rate_sel = 2'h0;
   logic zero_stuff = 1'b0;
   logic go = 1'b0;
   logic signed [15:0] amp = 16'sh0000;
   logic busy, in_vld, out_vld;
   logic signed [15:0] i_in, q_in, i_out, q_out;
   int mismatches = 0;
   int comparisons = 0;
   int cyc = 0;
   int fin = -1;
   int fout = -1;
   logic [15:0] oi [$];
   logic [15:0] oq [$];
   longint y [0:511];
   longint t [0:511];

   hbi_chain dut (.clk_sys(clk_sys), .rst(rst), .rate_sel(rate_sel), .zero_stuff(zero_stuff),
      .in_vld(in_vld), .i_in(i_in), .q_in(q_in), .out_vld(out_vld), .i_out(i_out), .q_out(q_out));
   hbi_src src (.clk_sys(clk_sys), .rst(rst), .go(go), .rate(rate_sel), .amp(amp), .busy(busy),
      .in_vld(in_vld), .i_in(i_in), .q_in(q_in));

   // 250 MHz clock
   always #2 clk_sys = ~clk_sys;
   // Edge index of the first accepted sample
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (in_vld === 1'b1 && fin < 0) fin = cyc;
   end
   // Outputs sampled mid-cycle, well away from the launching edge
   always @(negedge clk_sys) begin
      if (out_vld === 1'b1) begin
         if (fout < 0) fout = cyc - 1;
         oi.push_back(i_out);
         oq.push_back(q_out);
      end
   end

   // Full tap j of stage s, zeros and centre included
   function automatic longint tap(input int s, input int j);
      int c;
      int d;
      c = (ntap[s] - 1) / 2;
      d = (j <= c) ? j : ntap[s] - 1 - j;
      if (j < 0 || j >= ntap[s]) return 0;
      if (j == c) return longint'(1) << csh[s];
      return (d % 2 == 1) ? 0 : side[s][d / 2];
   endfunction
   // Impulse response of the cascade, floored and clamped per stage
   task automatic build(input int r, input int z, input longint a);
      int len;
      longint acc;
      y = '{default: 0};
      y[0] = a;
      len = 1;
      for (int s = 0; s < r; s++) begin
         t = y;
         for (int m = 0; m < 2 * len - 1 + ntap[s]; m++) begin
            acc = 0;
            for (int k = 0; k < len; k++) acc += t[k] * tap(s, m - 2 * k);
            acc = acc >>> (csh[s] + z);
            y[m] = (acc > 32767) ? 32767 : (acc < -32768) ? -32768 : acc;
         end
         len = 2 * len - 1 + ntap[s];
      end
   endtask
   task automatic cmp_smp(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_num(input int got, input int exp);
      comparisons++;
      if (got != exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      if (mismatches == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic start;
      go <= 1'b1;
      @(negedge clk_sys);
      go <= 1'b0;
      @(negedge clk_sys);
   endtask
   // Bounded wait for the source to finish its burst
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy === 1'b1 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 2000) begin
         mismatches++;
         summarize();
      end
   endtask
   task automatic run(input hbi_row_t w, input bit rs);
      rate_sel <= w.r;
      zero_stuff <= w.z;
      amp <= w.a;
      @(negedge clk_sys);
      if (rs) begin
         rst <= 1'b1;
         repeat (4) @(negedge clk_sys);
         rst <= 1'b0;
      end
      oi.delete();
      oq.delete();
      fin = -1;
      fout = -1;
      start();
      wait_idle();
      repeat (20) @(negedge clk_sys);
      cmp_num(oi.size(), w.nout);
      cmp_num(fout - fin, w.lat);
      build(w.r, w.z, w.a);
      foreach (oi[k]) cmp_smp(oi[k], y[k][15:0]);
      build(w.r, w.z, -w.a);
      foreach (oq[k]) cmp_smp(oq[k], y[k][15:0]);
   endtask

   // Table of ordinary cases, then an aborted burst
   initial begin
      foreach (rows[k]) run(rows[k], 1'b1);
      // Reset in mid-burst must clear outputs and filter history
      rate_sel <= 2'h3;
      start();
      repeat (30) @(negedge clk_sys);
      rst <= 1'b1;
      repeat (9) begin
         @(negedge clk_sys);
         cmp_smp(i_out | q_out | 16'(out_vld), 16'h0000);
      end
      rst <= 1'b0;
      @(negedge clk_sys);
      cmp_smp(i_out | q_out | 16'(out_vld), 16'h0000);
      @(negedge clk_sys);
      cmp_smp(i_out | q_out | 16'(out_vld), 16'h0000);
      wait_idle();
      // No extra reset, so leftover history would show in the response
      run(rows[1], 1'b0);
      summarize();
   end
   // Watchdog well beyond the expected run length
   initial begin
      #100000;
      mismatches++;
      summarize();
   end
endmodule
`default_nettype wire
